/* conv_regs_asserts.sv */
// concurrent checks on the converter register bank ports
`timescale 1ns/10ps
module conv_regs_asserts
	import conv_regs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// converter controls
	input wire logic convAOn,
	input wire logic convAFixedFreq,
	input wire logic convAMultiphase,
	input wire logic convADischargeOn,
	input wire logic [2:0] convAPeakLimit,
	input wire logic [2:0] convASlew,
	input wire logic convBOn,
	input wire logic convBDischargeOn,
	input wire logic imageLoaded
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// a completed write that really lands in lane 0
	sequence wrTo(logic [7:0] a);
		pready && pwrite && pstrb[0] && paddr == a;
	endsequence

	a_ready_one_wait: assert property (psel && penable && !pready && imageLoaded |=> pready ##1 !pready)
		else $error("access not answered in one wait state");
	a_stall_load: assert property (pready |-> imageLoaded)
		else $error("answer before image load");
	a_read_clean: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
		else $error("read data outside a read answer");
	a_revision_zeros: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[7:6] == 2'h0 && prdata[2:0] == 3'h0)
		else $error("revision spare bits set");
	a_id_write_err: assert property (pready && pwrite && paddr[7:3] == 5'h00 && paddr[1:0] == 2'h0 |-> pslverr)
		else $error("identity write accepted");
	a_err_place: assert property (pslverr |-> pready && !(paddr inside {8'h08, 8'h0c, 8'h10}))
		else $error("error on a writable register");
	a_phase_mode: assert property (wrTo(8'h08) |-> ##2 convAMultiphase == $past(pwdata[5], 2) && convAFixedFreq == ($past(pwdata[4], 2) || $past(pwdata[5], 2)))
		else $error("mode outputs do not follow write");
	a_limit_apply: assert property (wrTo(8'h0c) ##0 pwdata[5:3] != 3'h7 |-> ##2 convAPeakLimit == $past(pwdata[5:3], 2))
		else $error("peak limit not applied");
	a_discharge_off: assert property (!(convADischargeOn && convAOn) && !(convBDischargeOn && convBOn))
		else $error("discharge while converter on");
	a_codes_legal: assert property (convAPeakLimit != 3'h7 && convASlew >= 3'h2)
		else $error("reserved code on outputs");
endmodule

bind converter_identity_control_regs conv_regs_asserts u_asserts (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .convAOn, .convAFixedFreq, .convAMultiphase, .convADischargeOn,
	.convAPeakLimit, .convASlew, .convBOn, .convBDischargeOn, .imageLoaded);

/* conv_regs_pkg.sv */
// constants, field layout and reset values of the converter identity and control registers
// What this block does
// RQ1: the revision register shows a read-only three-bit part variant field taken from the nonvolatile image.
// RQ2: the programming identity register shows a read-only six-bit image identity in its upper bits.
// RQ3: the programming identity register shows a read-only two-bit image version in its lowest bits.
// RQ4: bit zero of converter A's primary control register turns converter A on when one and off when zero.
// RQ5: a two-bit gating selector uses the enable bit alone for code 0, or ANDs it with external enable 1, 2 or 3.
// RQ6: the forced fixed-frequency bit keeps a converter in pulse-width operation, else it changes mode automatically.
// RQ7: converter A's forced multi-phase bit runs both phases with forced fixed frequency, else phases shed freely.
// RQ8: the discharge bit connects the output discharge resistor while the converter is off, and resets to one.
// RQ9: a three-bit peak current limit code picks 1.5 A to 4.5 A in half-amp steps, code 7 reserved, reset code 3.
// RQ10: a new peak current limit code takes effect at any time, even while the converter runs.
// RQ11: a three-bit slew code sets the ramp rate both ways, codes 0 and 1 reserved, reset code 2.
// RQ12: converter A's primary control register sits at index 2 and resets to 0x08, only discharge set.
// RQ13: converter A's limit register sits at index 3, resets to 0x1A, two reserved upper bits then limit and slew.
// RQ14: converter B's primary control register sits at index 4, resets to 0x08, same fields but no multi-phase bit.
// RQ15: converter B's gating selector uses the same encoding as converter A's.
// RQ16: fields defaulted from nonvolatile memory are loaded from the image after reset, before software access.
package conv_regs_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register indices; the byte address is four times the index
	localparam logic [2:0] IDX_DEVICE_REVISION = 3'h0;
	localparam logic [2:0] IDX_NVM_PROGRAM_IDENTITY = 3'h1;
	localparam logic [2:0] IDX_CONV_A_CONTROL_PRIMARY = 3'h2;
	localparam logic [2:0] IDX_CONV_A_CONTROL_LIMITS = 3'h3;
	localparam logic [2:0] IDX_CONV_B_CONTROL_PRIMARY = 3'h4;

	// field positions
	localparam int PART_VARIANT_LSB = 3;
	localparam int IMAGE_IDENTITY_LSB = 2;
	localparam int IMAGE_VERSION_LSB = 0;
	localparam int ENABLE_BIT = 0;
	localparam int PIN_GATING_LSB = 1;
	localparam int DISCHARGE_BIT = 3;
	localparam int FIXED_FREQ_BIT = 4;
	localparam int MULTIPHASE_BIT = 5;
	localparam int PEAK_LIMIT_LSB = 3;
	localparam int SLEW_LSB = 0;

	// printed reset values
	localparam logic [7:0] RST_CONV_CONTROL_PRIMARY = 8'h08;
	localparam logic [7:0] RST_CONV_CONTROL_LIMITS = 8'h1a;
	localparam logic [2:0] RST_PEAK_LIMIT = 3'h3;
	localparam logic [2:0] RST_SLEW = 3'h2;

	// reserved codes
	localparam logic [2:0] PEAK_LIMIT_RESERVED = 3'h7;
	localparam logic [2:0] SLEW_LOWEST_LEGAL = 3'h2;

	typedef enum logic [1:0] {
		GATE_BIT_ONLY = 2'h0,
		GATE_WITH_PIN1 = 2'h1,
		GATE_WITH_PIN2 = 2'h2,
		GATE_WITH_PIN3 = 2'h3
	} pin_gating_t;

	typedef enum logic [1:0] {
		LOAD_WAIT = 2'b01,
		LOAD_DONE = 2'b10
	} load_state_t;

endpackage

/* converter_identity_control_regs.sv */
// APB register bank for the identity registers and the two step-down converter controls
`timescale 1ns/10ps
module converter_identity_control_regs
	import conv_regs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// nonvolatile default image, static once nvmReady is high
	input wire logic nvmReady,
	input wire logic [2:0] nvmPartVariant,
	input wire logic [5:0] nvmImageIdentity,
	input wire logic [1:0] nvmImageVersion,
	input wire logic [7:0] nvmConvAControlPrimary,
	input wire logic [7:0] nvmConvAControlLimits,
	input wire logic [7:0] nvmConvBControlPrimary,
	// external enable pins, asynchronous
	input wire logic external_enable_input_1,
	input wire logic external_enable_input_2,
	input wire logic external_enable_input_3,
	// converter A analog controls
	output logic convAOn,
	output logic convAFixedFreq,
	output logic convAMultiphase,
	output logic convADischargeOn,
	output logic [2:0] convAPeakLimit,
	output logic [2:0] convASlew,
	// converter B analog controls
	output logic convBOn,
	output logic convBFixedFreq,
	output logic convBDischargeOn,
	// load status
	output logic imageLoaded
);

	logic [2:0] pinSync;
	load_state_t loadState_q;
	logic loaded;

	// identity fields
	logic [2:0] part_variant_field_q;
	logic [5:0] nvm_image_identity_q;
	logic [1:0] nvm_image_version_q;

	// converter fields
	logic conv_a_enable_q;
	logic [1:0] conv_a_pin_gating_select_q;
	logic conv_a_discharge_enable_q;
	logic conv_a_forced_fixed_freq_q;
	logic conv_a_forced_multiphase_q;
	logic [2:0] conv_a_peak_current_limit_q;
	logic [2:0] conv_a_slew_select_q;
	logic conv_b_enable_q;
	logic [1:0] conv_b_pin_gating_select_q;
	logic conv_b_discharge_enable_q;
	logic conv_b_forced_fixed_freq_q;

	// bus decode
	logic access;
	logic wrStrobe;
	logic [2:0] regIndex;
	logic aligned;
	logic mapped;
	logic readOnly;
	logic lane0;
	logic [7:0] readByte;
	logic [7:0] wrByte;
	logic convAGate;
	logic convBGate;

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.asyncIn({external_enable_input_3, external_enable_input_2, external_enable_input_1}),
		.syncOut(pinSync)
	);

	// image copy happens on the edge that leaves LOAD_WAIT; the bus stalls until then
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			loadState_q <= LOAD_WAIT;
		end else begin
			unique case (loadState_q)
				LOAD_WAIT: begin
					if (nvmReady) begin
						loadState_q <= LOAD_DONE; // [RQ16]
					end
				end
				LOAD_DONE: begin
					loadState_q <= LOAD_DONE;
				end
				default: begin
					loadState_q <= LOAD_WAIT;
				end
			endcase
		end
	end

	assign loaded = (loadState_q == LOAD_DONE);
	wire loadNow = (loadState_q == LOAD_WAIT) && nvmReady;

	// APB decode: one wait state, write lands on the completing edge
	assign access = psel && penable && loaded;
	assign wrStrobe = access && pready && pwrite;
	assign regIndex = paddr[4:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
	assign mapped = aligned && (regIndex <= IDX_CONV_B_CONTROL_PRIMARY);
	assign readOnly = (regIndex == IDX_DEVICE_REVISION) || (regIndex == IDX_NVM_PROGRAM_IDENTITY);
	assign lane0 = pstrb[0];
	assign wrByte = pwdata[7:0];

	// identity registers only ever change at the image load
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			part_variant_field_q <= 3'h0;
			nvm_image_identity_q <= 6'h00;
			nvm_image_version_q <= 2'h0;
		end else if (loadNow) begin
			part_variant_field_q <= nvmPartVariant; // [RQ1] [RQ16]
			nvm_image_identity_q <= nvmImageIdentity; // [RQ2]
			nvm_image_version_q <= nvmImageVersion; // [RQ3]
		end
	end

	// converter A primary control
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			conv_a_enable_q <= RST_CONV_CONTROL_PRIMARY[ENABLE_BIT]; // [RQ12]
			conv_a_pin_gating_select_q <= RST_CONV_CONTROL_PRIMARY[PIN_GATING_LSB +: 2];
			conv_a_discharge_enable_q <= RST_CONV_CONTROL_PRIMARY[DISCHARGE_BIT]; // [RQ8]
			conv_a_forced_fixed_freq_q <= RST_CONV_CONTROL_PRIMARY[FIXED_FREQ_BIT];
			conv_a_forced_multiphase_q <= RST_CONV_CONTROL_PRIMARY[MULTIPHASE_BIT];
		end else if (loadNow) begin
			// discharge is not an image field, so it keeps its reset value
			conv_a_enable_q <= nvmConvAControlPrimary[ENABLE_BIT]; // [RQ16]
			conv_a_pin_gating_select_q <= nvmConvAControlPrimary[PIN_GATING_LSB +: 2];
			conv_a_forced_fixed_freq_q <= nvmConvAControlPrimary[FIXED_FREQ_BIT];
			conv_a_forced_multiphase_q <= nvmConvAControlPrimary[MULTIPHASE_BIT];
		end else if (wrStrobe && lane0 && mapped && regIndex == IDX_CONV_A_CONTROL_PRIMARY) begin
			conv_a_enable_q <= wrByte[ENABLE_BIT]; // [RQ4]
			conv_a_pin_gating_select_q <= wrByte[PIN_GATING_LSB +: 2]; // [RQ5]
			conv_a_discharge_enable_q <= wrByte[DISCHARGE_BIT]; // [RQ8]
			conv_a_forced_fixed_freq_q <= wrByte[FIXED_FREQ_BIT]; // [RQ6]
			conv_a_forced_multiphase_q <= wrByte[MULTIPHASE_BIT]; // [RQ7]
		end
	end

	// converter A limits; a reserved code leaves the field as it was, so the analog side never sees one
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			conv_a_peak_current_limit_q <= RST_CONV_CONTROL_LIMITS[PEAK_LIMIT_LSB +: 3]; // [RQ9] [RQ13]
			conv_a_slew_select_q <= RST_CONV_CONTROL_LIMITS[SLEW_LSB +: 3]; // [RQ11]
		end else if (loadNow) begin
			if (nvmConvAControlLimits[PEAK_LIMIT_LSB +: 3] != PEAK_LIMIT_RESERVED) begin
				conv_a_peak_current_limit_q <= nvmConvAControlLimits[PEAK_LIMIT_LSB +: 3]; // [RQ16]
			end
			if (nvmConvAControlLimits[SLEW_LSB +: 3] >= SLEW_LOWEST_LEGAL) begin
				conv_a_slew_select_q <= nvmConvAControlLimits[SLEW_LSB +: 3];
			end
		end else if (wrStrobe && lane0 && mapped && regIndex == IDX_CONV_A_CONTROL_LIMITS) begin
			// no dependence on the enable: the limit may change while running
			if (wrByte[PEAK_LIMIT_LSB +: 3] != PEAK_LIMIT_RESERVED) begin
				conv_a_peak_current_limit_q <= wrByte[PEAK_LIMIT_LSB +: 3]; // [RQ9] [RQ10]
			end
			if (wrByte[SLEW_LSB +: 3] >= SLEW_LOWEST_LEGAL) begin
				conv_a_slew_select_q <= wrByte[SLEW_LSB +: 3]; // [RQ11]
			end
		end
	end

	// converter B primary control
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			conv_b_enable_q <= RST_CONV_CONTROL_PRIMARY[ENABLE_BIT]; // [RQ14]
			conv_b_pin_gating_select_q <= RST_CONV_CONTROL_PRIMARY[PIN_GATING_LSB +: 2];
			conv_b_discharge_enable_q <= RST_CONV_CONTROL_PRIMARY[DISCHARGE_BIT];
			conv_b_forced_fixed_freq_q <= RST_CONV_CONTROL_PRIMARY[FIXED_FREQ_BIT];
		end else if (loadNow) begin
			conv_b_enable_q <= nvmConvBControlPrimary[ENABLE_BIT]; // [RQ16]
			conv_b_pin_gating_select_q <= nvmConvBControlPrimary[PIN_GATING_LSB +: 2];
			conv_b_forced_fixed_freq_q <= nvmConvBControlPrimary[FIXED_FREQ_BIT];
		end else if (wrStrobe && lane0 && mapped && regIndex == IDX_CONV_B_CONTROL_PRIMARY) begin
			conv_b_enable_q <= wrByte[ENABLE_BIT]; // [RQ14]
			conv_b_pin_gating_select_q <= wrByte[PIN_GATING_LSB +: 2]; // [RQ15]
			conv_b_discharge_enable_q <= wrByte[DISCHARGE_BIT]; // [RQ8]
			conv_b_forced_fixed_freq_q <= wrByte[FIXED_FREQ_BIT]; // [RQ6]
		end
	end

	// read mux; reserved bits read as zero
	always_comb begin
		readByte = 8'h00;
		unique case (regIndex)
			IDX_DEVICE_REVISION: begin
				readByte[PART_VARIANT_LSB +: 3] = part_variant_field_q; // [RQ1]
			end
			IDX_NVM_PROGRAM_IDENTITY: begin
				readByte[IMAGE_IDENTITY_LSB +: 6] = nvm_image_identity_q; // [RQ2]
				readByte[IMAGE_VERSION_LSB +: 2] = nvm_image_version_q; // [RQ3]
			end
			IDX_CONV_A_CONTROL_PRIMARY: begin
				readByte[ENABLE_BIT] = conv_a_enable_q;
				readByte[PIN_GATING_LSB +: 2] = conv_a_pin_gating_select_q;
				readByte[DISCHARGE_BIT] = conv_a_discharge_enable_q;
				readByte[FIXED_FREQ_BIT] = conv_a_forced_fixed_freq_q;
				readByte[MULTIPHASE_BIT] = conv_a_forced_multiphase_q;
			end
			IDX_CONV_A_CONTROL_LIMITS: begin
				readByte[PEAK_LIMIT_LSB +: 3] = conv_a_peak_current_limit_q; // [RQ13]
				readByte[SLEW_LSB +: 3] = conv_a_slew_select_q;
			end
			IDX_CONV_B_CONTROL_PRIMARY: begin
				readByte[ENABLE_BIT] = conv_b_enable_q;
				readByte[PIN_GATING_LSB +: 2] = conv_b_pin_gating_select_q;
				readByte[DISCHARGE_BIT] = conv_b_discharge_enable_q;
				readByte[FIXED_FREQ_BIT] = conv_b_forced_fixed_freq_q;
			end
			default: begin
				readByte = 8'h00;
			end
		endcase
		if (!mapped) begin
			readByte = 8'h00;
		end
	end

	// APB answer: pready rises in the second access cycle and stands one cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (access && !pready) begin
			pready <= 1'b1;
			pslverr <= !mapped || (pwrite && readOnly);
			prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	// pin gating selection
	always_comb begin
		unique case (pin_gating_t'(conv_a_pin_gating_select_q))
			GATE_BIT_ONLY: convAGate = 1'b1; // [RQ5]
			GATE_WITH_PIN1: convAGate = pinSync[0];
			GATE_WITH_PIN2: convAGate = pinSync[1];
			GATE_WITH_PIN3: convAGate = pinSync[2];
		endcase
		unique case (pin_gating_t'(conv_b_pin_gating_select_q))
			GATE_BIT_ONLY: convBGate = 1'b1; // [RQ15]
			GATE_WITH_PIN1: convBGate = pinSync[0];
			GATE_WITH_PIN2: convBGate = pinSync[1];
			GATE_WITH_PIN3: convBGate = pinSync[2];
		endcase
	end

	// analog controls are registered, so they trail the fields by one cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			convAOn <= 1'b0;
			convAFixedFreq <= 1'b0;
			convAMultiphase <= 1'b0;
			convADischargeOn <= 1'b0;
			convAPeakLimit <= RST_PEAK_LIMIT;
			convASlew <= RST_SLEW;
			convBOn <= 1'b0;
			convBFixedFreq <= 1'b0;
			convBDischargeOn <= 1'b0;
			imageLoaded <= 1'b0;
		end else begin
			// converters stay off until the image has been applied
			convAOn <= loaded && conv_a_enable_q && convAGate; // [RQ4] [RQ5]
			convAFixedFreq <= conv_a_forced_fixed_freq_q || conv_a_forced_multiphase_q; // [RQ6] [RQ7]
			convAMultiphase <= conv_a_forced_multiphase_q; // [RQ7]
			convADischargeOn <= conv_a_discharge_enable_q && !(loaded && conv_a_enable_q && convAGate); // [RQ8]
			convAPeakLimit <= conv_a_peak_current_limit_q; // [RQ10]
			convASlew <= conv_a_slew_select_q; // [RQ11]
			convBOn <= loaded && conv_b_enable_q && convBGate; // [RQ14] [RQ15]
			convBFixedFreq <= conv_b_forced_fixed_freq_q; // [RQ6]
			convBDischargeOn <= conv_b_discharge_enable_q && !(loaded && conv_b_enable_q && convBGate); // [RQ8]
			imageLoaded <= loaded;
		end
	end

endmodule

/* converter_identity_control_regs_tb.sv */
// self-checking bench for the converter identity and control register bank
`timescale 1ns/10ps
module converter_identity_control_regs_tb
	import conv_regs_pkg::*;
;
	typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp; logic err;} row_t;
	logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nvmReady = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [2:0] pins = 3'h7, part = 3'h5, convAPeakLimit, convASlew;
	logic [5:0] ident = 6'h2b;
	logic [1:0] vers = 2'h2;
	logic [7:0] primA = 8'h10, limA = 8'h2c, primB = 8'h17;
	logic pready, pslverr, convAOn, convAFixedFreq, convAMultiphase, convADischargeOn, er;
	logic convBOn, convBFixedFreq, convBDischargeOn, imageLoaded;
	logic [7:0] modes[3] = '{8'h20, 8'h10, 8'h01};
	int mismatches = 0, comparisons = 0;
	// rows 0..15 run on the first image, 16..19 after a reset with reserved image codes
	row_t rows[20] = '{'{1'b0, 8'h00, 8'h00, 8'h28, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'hae, 1'b0},
		'{1'b0, 8'h08, 8'h00, 8'h18, 1'b0}, '{1'b0, 8'h0c, 8'h00, 8'h2c, 1'b0}, '{1'b0, 8'h10, 8'h00, 8'h1f, 1'b0},
		'{1'b1, 8'h00, 8'hff, 8'h00, 1'b1}, '{1'b1, 8'h04, 8'hff, 8'h00, 1'b1}, '{1'b0, 8'h00, 8'h00, 8'h28, 1'b0},
		'{1'b0, 8'h14, 8'h00, 8'h00, 1'b1}, '{1'b0, 8'h0a, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h0c, 8'hff, 8'h00, 1'b0},
		'{1'b0, 8'h0c, 8'h00, 8'h2f, 1'b0}, '{1'b1, 8'h0c, 8'h01, 8'h00, 1'b0}, '{1'b0, 8'h0c, 8'h00, 8'h07, 1'b0},
		'{1'b1, 8'h10, 8'hff, 8'h00, 1'b0}, '{1'b0, 8'h10, 8'h00, 8'h1f, 1'b0}, '{1'b0, 8'h08, 8'h00, 8'h08, 1'b0},
		'{1'b0, 8'h0c, 8'h00, 8'h1a, 1'b0}, '{1'b0, 8'h10, 8'h00, 8'h08, 1'b0}, '{1'b0, 8'h00, 8'h00, 8'h00, 1'b0}};

	converter_identity_control_regs dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nvmReady(nvmReady), .nvmPartVariant(part), .nvmImageIdentity(ident),
		.nvmImageVersion(vers), .nvmConvAControlPrimary(primA), .nvmConvAControlLimits(limA),
		.nvmConvBControlPrimary(primB), .external_enable_input_1(pins[0]), .external_enable_input_2(pins[1]),
		.external_enable_input_3(pins[2]), .convAOn(convAOn), .convAFixedFreq(convAFixedFreq),
		.convAMultiphase(convAMultiphase), .convADischargeOn(convADischargeOn), .convAPeakLimit(convAPeakLimit),
		.convASlew(convASlew), .convBOn(convBOn), .convBFixedFreq(convBFixedFreq),
		.convBDischargeOn(convBDischargeOn), .imageLoaded(imageLoaded));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// each call starts on a fresh edge so psel is never assigned twice in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			$display("BAD %0t no answer from slave", $time);
			mismatches++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic doRow(input row_t r);
		apb(r.wr, r.addr, {24'h00_0000, r.data});
		check(rd, {24'h00_0000, r.exp});
		check(32'(er), 32'(r.err));
	endtask

	initial begin
		cyc(5);
		check(32'({convAPeakLimit, convASlew}), 32'h0000_001a);
		nrst <= 1'b1;
		cyc(3);
		// image not ready yet: converters held off, discharge applied
		check(32'({imageLoaded, convADischargeOn, convBDischargeOn, convAOn}), 32'h0000_0006);
		nvmReady <= 1'b1;
		for (int i = 0; i < 16; i++) doRow(rows[i]);
		for (int c = 0; c < 2; c++) begin
			for (int g = 0; g < 4; g++) begin
				pins <= 3'h7;
				apb(1'b1, c ? 8'h10 : 8'h08, 32'h0000_0009 | 32'(g << 1));
				cyc(4);
				check(32'(c ? convBOn : convAOn), 32'h0000_0001);
				pins <= (g == 0) ? 3'h0 : ~(3'h1 << (g - 1));
				cyc(4);
				check(32'(c ? convBOn : convAOn), 32'(g == 0));
				check(32'(c ? convBDischargeOn : convADischargeOn), 32'(g != 0));
			end
		end
		foreach (modes[i]) begin
			apb(1'b1, 8'h08, {24'h00_0000, modes[i]});
			apb(1'b1, 8'h10, {24'h00_0000, modes[i]});
			cyc(2);
			check(32'({convAMultiphase, convAFixedFreq}), 32'({modes[i][5], modes[i][5] | modes[i][4]}));
			check(32'(convBFixedFreq), 32'(modes[i][4]));
		end
		// a write without lane 0 completes but must leave converter A's control as it was
		pstrb <= 4'he;
		doRow(row_t'{1'b1, 8'h08, 8'h00, 8'h00, 1'b0});
		pstrb <= 4'hf;
		doRow(row_t'{1'b0, 8'h08, 8'h00, 8'h01, 1'b0});
		// limit change while converter A runs; reserved slew code keeps the old rate
		apb(1'b1, 8'h0c, 32'h0000_0008);
		cyc(2);
		check(32'({convAOn, convAPeakLimit, convASlew}), 32'h0000_004f);
		nrst <= 1'b0;
		{part, ident, vers, primA, primB, nvmReady} <= '0;
		limA <= 8'h39;
		cyc(5);
		nrst <= 1'b1;
		// image arrives late: the first access must stall until the copy is done
		fork
			doRow(rows[16]);
			begin
				cyc(6);
				check(32'(pready), 32'h0000_0000);
				nvmReady <= 1'b1;
			end
		join
		for (int i = 17; i < 20; i++) doRow(rows[i]);
		stop_test();
	end
endmodule

/* pin_sync.sv */
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// levels
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			stage1_q <= '0;
			stage2_q <= '0;
		end else begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
		end
	end

	assign syncOut = stage2_q;

endmodule
